// File: rtl/t2r_ext_div.sv
// module: external oscillator synchroniser and divide-by-eight event source
module t2r_ext_div
	import t2r_pkg::*;
#(
	parameter int EXT_DIVIDE = T2R_EXT_DIVIDE
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ext_osc,
	output logic      ext_fall_tick
);
	localparam int DW = $clog2(EXT_DIVIDE);
	localparam logic [DW-1:0] DIV_LAST = DW'(EXT_DIVIDE - 1);

	logic          sync1_reg;   // first synchroniser stage, read only by stage two
	logic          sync2_reg;   // second stage, safe to use
	logic          prev_reg;    // last safe level, for edge detection
	logic [DW-1:0] div_reg;     // counts rising edges of the oscillator

	// two-flop synchroniser: the pin is asynchronous to clk
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg  <= 1'b0;
		end
		else
		begin
			sync1_reg <= ext_osc;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// divide by eight; the falling edge of the divided clock is the wrap
	// of this counter, so one pulse per eight oscillator periods
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_reg       <= '0;
			ext_fall_tick <= 1'b0;
		end
		else
		begin
			ext_fall_tick <= 1'b0;
			if (sync2_reg && !prev_reg)
			begin
				div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
				// divided clock falls as the count wraps
				ext_fall_tick <= (div_reg == DIV_LAST);
			end
		end
	end

	// the event is a single-cycle pulse
	single_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		ext_fall_tick |=> !ext_fall_tick)
		else $error("divided external event lasted more than one cycle");
endmodule : t2r_ext_div

// File: rtl/t2r_pkg.sv
// package: register addresses, field positions, reset values and divider counts
package t2r_pkg;
	// register addresses on the special function register bus
	localparam logic [7:0] T2R_ADDR_CONTROL     = 8'hc8;
	localparam logic [7:0] T2R_ADDR_RELOAD_LOW  = 8'hca;
	localparam logic [7:0] T2R_ADDR_RELOAD_HIGH = 8'hcb;
	localparam logic [7:0] T2R_ADDR_COUNT_LOW   = 8'hcc;
	localparam logic [7:0] T2R_ADDR_COUNT_HIGH  = 8'hcd;
	// control register field positions
	localparam int T2R_BIT_HIGH_FLAG  = 7;
	localparam int T2R_BIT_LOW_FLAG   = 6;
	localparam int T2R_BIT_LOW_IRQ_EN = 5;
	localparam int T2R_BIT_CAPTURE_EN = 4;
	localparam int T2R_BIT_SPLIT      = 3;
	localparam int T2R_BIT_RUN        = 2;
	localparam int T2R_BIT_EXT_SELECT = 0;
	// reset values
	localparam logic [7:0] T2R_CONTROL_RESET = 8'h00;
	localparam logic [7:0] T2R_BYTE_RESET    = 8'h00;
	// byte boundaries for rollover detection
	localparam logic [7:0] T2R_BYTE_MAX  = 8'hff;
	localparam logic [7:0] T2R_BYTE_ZERO = 8'h00;
	// divider counts
	localparam int T2R_SYS_DIVIDE = 12;
	localparam int T2R_EXT_DIVIDE = 8;
endpackage : t2r_pkg

// File: rtl/t2r_timer.sv
// module: timer two with 16-bit or split 8-bit auto-reload and capture
// Behaviour
// - 16-bit mode reloads and sets high flag
// - timer interrupt on every overflow when enabled
// - low rollover interrupts when low enable set
// - split mode: two 8-bit auto-reload counters
// - run gates all, or high byte only
// - per-byte system clock select, else shared /12 or ext/8
// - external divide-by-eight synchronised to system clock
// - split mode: each byte sets its flag
// - low flag set on every low rollover
// - split interrupt on high, or either byte
// - flags never cleared by hardware
// - capture copies counter to reload, sets flag
// - capture on divided external clock falling edge
// - control bit four enables capture mode
// - control register field layout as defined
// - control bit one reads zero, ignores writes
// - reload and count registers, reset zero
// - high clock select only matters in split
module t2r_timer
	import t2r_pkg::*;
#(
	parameter int SYS_DIVIDE = T2R_SYS_DIVIDE,
	parameter int EXT_DIVIDE = T2R_EXT_DIVIDE
)
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr_en,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       timer_irq_enable,
	input  wire logic       high_byte_clock_select,
	input  wire logic       low_byte_clock_select,
	input  wire logic       ext_osc,
	output logic            timer_irq
);
	localparam int PW = $clog2(SYS_DIVIDE);
	localparam logic [PW-1:0] PRE_LAST = PW'(SYS_DIVIDE - 1);

	logic          rst_meta_reg;         // reset release, first stage
	logic          rst_sync_n;           // reset used by the whole design
	logic [PW-1:0] pre_reg;              // system clock divide-by-twelve
	logic          pre_tick;             // one pulse per twelve clocks
	logic          ext_tick;             // divided external clock falling edge
	logic          high_overflow_flag;   // control bit 7
	logic          low_overflow_flag;    // control bit 6
	logic          low_interrupt_enable; // control bit 5
	logic          capture_enable;       // control bit 4
	logic          split_mode_bit;       // control bit 3
	logic          run_bit;              // control bit 2
	logic          external_clock_select;// control bit 0
	logic [7:0]    count_low_byte;       // low counter byte
	logic [7:0]    count_high_byte;      // high counter byte
	logic [7:0]    reload_low_byte;      // low reload / capture byte
	logic [7:0]    reload_high_byte;     // high reload / capture byte
	logic          wr_ctrl;              // write strobes per register
	logic          wr_rl_low;
	logic          wr_rl_high;
	logic          wr_cnt_low;
	logic          wr_cnt_high;
	logic          low_tick;             // clock enable chosen for low byte
	logic          high_tick;            // clock enable chosen for high byte
	logic          low_en;               // low byte advances this cycle
	logic          high_en;              // high byte advances this cycle
	logic          low_wrap;             // low byte rolls over from 0xff
	logic          high_wrap;            // high byte (or whole 16 bits) rolls
	logic          full_wrap;            // 16-bit rollover
	logic          capture_event;        // capture strobe
	logic [7:0]    rdata_next;           // read mux result

	// reset is asserted at once but released through two flops
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_n   <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_n   <= rst_meta_reg;
		end
	end

	// external oscillator divided by eight, brought into this clock
	t2r_ext_div #(
		.EXT_DIVIDE (EXT_DIVIDE)
	) t2r_ext_div_i (
		.clk           (clk),
		.rst_n         (rst_sync_n),
		.ext_osc       (ext_osc),
		.ext_fall_tick (ext_tick)
	);

	// free-running divide-by-twelve prescaler, shared by both bytes
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			pre_reg <= '0;
		else
			pre_reg <= (pre_reg == PRE_LAST) ? '0 : pre_reg + 1'b1;
	end
	assign pre_tick = (pre_reg == PRE_LAST);

	// address decode
	assign wr_ctrl     = sfr_wr_en && (sfr_addr == T2R_ADDR_CONTROL);
	assign wr_rl_low   = sfr_wr_en && (sfr_addr == T2R_ADDR_RELOAD_LOW);
	assign wr_rl_high  = sfr_wr_en && (sfr_addr == T2R_ADDR_RELOAD_HIGH);
	assign wr_cnt_low  = sfr_wr_en && (sfr_addr == T2R_ADDR_COUNT_LOW);
	assign wr_cnt_high = sfr_wr_en && (sfr_addr == T2R_ADDR_COUNT_HIGH);

	// clock source per byte; the high select only applies in split mode,
	// in 16-bit mode the high byte is carried from the low byte instead
	assign low_tick  = low_byte_clock_select ? 1'b1 :
		(external_clock_select ? ext_tick : pre_tick);
	assign high_tick = (split_mode_bit && high_byte_clock_select) ? 1'b1 :
		(external_clock_select ? ext_tick : pre_tick);

	// run gates the whole timer in 16-bit mode, only the high byte in split
	assign low_en  = split_mode_bit ? low_tick : (run_bit && low_tick);
	assign high_en = split_mode_bit ? (run_bit && high_tick)
		: (low_en && count_low_byte == T2R_BYTE_MAX);
	assign low_wrap  = low_en && (count_low_byte == T2R_BYTE_MAX);
	assign high_wrap = high_en && (count_high_byte == T2R_BYTE_MAX);
	assign full_wrap = !split_mode_bit && high_wrap;

	// capture strobe; the capture rewrites the reload pair and sets the high flag
	assign capture_event = capture_enable && ext_tick;

	// control fields written by software; bit 1 has no storage at all
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			low_interrupt_enable  <= T2R_CONTROL_RESET[T2R_BIT_LOW_IRQ_EN];
			capture_enable        <= T2R_CONTROL_RESET[T2R_BIT_CAPTURE_EN];
			split_mode_bit        <= T2R_CONTROL_RESET[T2R_BIT_SPLIT];
			run_bit               <= T2R_CONTROL_RESET[T2R_BIT_RUN];
			external_clock_select <= T2R_CONTROL_RESET[T2R_BIT_EXT_SELECT];
		end
		else if (wr_ctrl)
		begin
			// field layout of the control register
			low_interrupt_enable  <= sfr_wdata[T2R_BIT_LOW_IRQ_EN];
			capture_enable        <= sfr_wdata[T2R_BIT_CAPTURE_EN];
			split_mode_bit        <= sfr_wdata[T2R_BIT_SPLIT];
			run_bit               <= sfr_wdata[T2R_BIT_RUN];
			external_clock_select <= sfr_wdata[T2R_BIT_EXT_SELECT];
		end
	end

	// high flag: set by any high rollover or capture; only software clears
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			high_overflow_flag <= T2R_CONTROL_RESET[T2R_BIT_HIGH_FLAG];
		else if (high_wrap || capture_event)
			high_overflow_flag <= 1'b1;
		else if (wr_ctrl)
			high_overflow_flag <= sfr_wdata[T2R_BIT_HIGH_FLAG];
	end

	// low flag: set on every low rollover regardless of mode
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			low_overflow_flag <= T2R_CONTROL_RESET[T2R_BIT_LOW_FLAG];
		else if (low_wrap)
			low_overflow_flag <= 1'b1;
		else if (wr_ctrl)
			low_overflow_flag <= sfr_wdata[T2R_BIT_LOW_FLAG];
	end

	// low counter byte; a software write wins over counting so that
	// firmware can preset the byte while the timer runs
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			count_low_byte <= T2R_BYTE_RESET;
		else if (wr_cnt_low)
			count_low_byte <= sfr_wdata;
		else if (low_wrap && (split_mode_bit || full_wrap))
			count_low_byte <= reload_low_byte;
		else if (low_wrap)
			count_low_byte <= T2R_BYTE_ZERO; // carry into high byte
		else if (low_en)
			count_low_byte <= count_low_byte + 8'h01;
	end

	// high counter byte
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			count_high_byte <= T2R_BYTE_RESET;
		else if (wr_cnt_high)
			count_high_byte <= sfr_wdata;
		else if (high_wrap)
			count_high_byte <= reload_high_byte;
		else if (high_en)
			count_high_byte <= count_high_byte + 8'h01;
	end

	// reload pair; a capture beats a software write in the same cycle,
	// since losing a measurement is worse than a retried write
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			reload_low_byte  <= T2R_BYTE_RESET;
			reload_high_byte <= T2R_BYTE_RESET;
		end
		else if (capture_event)
		begin
			reload_low_byte  <= count_low_byte;
			reload_high_byte <= count_high_byte;
		end
		else
		begin
			if (wr_rl_low)
				reload_low_byte <= sfr_wdata;
			if (wr_rl_high)
				reload_high_byte <= sfr_wdata;
		end
	end

	// interrupt request is a level that follows the sticky flags; it
	// stays up until software clears the flag causing it
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			timer_irq <= 1'b0;
		else
			timer_irq <= timer_irq_enable && (high_overflow_flag ||
				(low_interrupt_enable && low_overflow_flag));
	end

	// read mux; unused addresses and control bit 1 read as zero
	always_comb
	begin
		rdata_next = 8'h00;
		case (sfr_addr)
			T2R_ADDR_CONTROL:
			begin
				rdata_next[T2R_BIT_HIGH_FLAG]  = high_overflow_flag;
				rdata_next[T2R_BIT_LOW_FLAG]   = low_overflow_flag;
				rdata_next[T2R_BIT_LOW_IRQ_EN] = low_interrupt_enable;
				rdata_next[T2R_BIT_CAPTURE_EN] = capture_enable;
				rdata_next[T2R_BIT_SPLIT]      = split_mode_bit;
				rdata_next[T2R_BIT_RUN]        = run_bit;
				rdata_next[T2R_BIT_EXT_SELECT] = external_clock_select;
			end
			T2R_ADDR_RELOAD_LOW:  rdata_next = reload_low_byte;
			T2R_ADDR_RELOAD_HIGH: rdata_next = reload_high_byte;
			T2R_ADDR_COUNT_LOW:   rdata_next = count_low_byte;
			T2R_ADDR_COUNT_HIGH:  rdata_next = count_high_byte;
			default:              rdata_next = 8'h00;
		endcase
	end

	// read data registered: valid one cycle after the address
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			sfr_rdata <= 8'h00;
		else
			sfr_rdata <= rdata_next;
	end

	// checks on the counting and flag behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_sync_n);

	logic [15:0] count_w;   // helper: whole counter
	logic [15:0] reload_w;  // helper: whole reload pair
	logic        no_cnt_wr; // helper: no software write to the counter
	assign count_w   = {count_high_byte, count_low_byte};
	assign reload_w  = {reload_high_byte, reload_low_byte};
	assign no_cnt_wr = !wr_cnt_low && !wr_cnt_high;

	wrap_reload_a: assert property (
		!split_mode_bit && low_en && count_w == 16'hffff && no_cnt_wr
		|=> count_w == $past(reload_w) && high_overflow_flag)
		else $error("16-bit rollover did not reload or flag");

	irq_high_a: assert property (
		high_overflow_flag && timer_irq_enable |=> timer_irq)
		else $error("high flag with enable gave no interrupt");

	irq_low_a: assert property (
		low_wrap && !wr_ctrl && low_interrupt_enable && timer_irq_enable
		&& !wr_ctrl ##1 timer_irq_enable |=> timer_irq)
		else $error("low rollover gave no interrupt");

	irq_quiet_a: assert property (
		!high_overflow_flag && !low_overflow_flag |=> !timer_irq)
		else $error("interrupt without a flag");

	split_low_a: assert property (
		split_mode_bit && low_wrap && !wr_cnt_low
		|=> count_low_byte == $past(reload_low_byte))
		else $error("split low byte failed to reload");

	run_hold_a: assert property (
		!run_bit && !split_mode_bit && no_cnt_wr |=> $stable(count_w))
		else $error("stopped 16-bit timer moved");

	low_flag_a: assert property (
		low_wrap |=> low_overflow_flag)
		else $error("low rollover did not set low flag");

	sticky_flag_a: assert property (
		high_overflow_flag && !wr_ctrl |=> high_overflow_flag)
		else $error("high flag cleared without software");

	capture_a: assert property (
		capture_event |=> reload_w == $past(count_w) && high_overflow_flag)
		else $error("capture did not copy counter");

	bit_one_a: assert property (
		sfr_addr == T2R_ADDR_CONTROL |=> sfr_rdata[1] == 1'b0)
		else $error("control bit one read nonzero");

	set_wins_a: assert property (
		wr_ctrl && !sfr_wdata[T2R_BIT_LOW_FLAG] && low_wrap
		|=> low_overflow_flag)
		else $error("software clear beat hardware set");

	cov_full_wrap: cover property (full_wrap);
	cov_split_both: cover property (split_mode_bit && low_wrap ##[1:600] high_wrap);
	cov_capture: cover property (capture_event ##[1:1000] capture_event);
	cov_irq: cover property (!timer_irq ##1 timer_irq);
endmodule : t2r_timer

// File: tb/t2r_timer_tb.sv
// testbench: register access, overflow, split, clock rate and capture checks on timer two
module t2r_timer_tb
	import t2r_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic       clk;                    // system clock, 100 ns period
	logic       reset_n;                // active low reset
	logic [7:0] sfr_addr;               // register address
	logic       sfr_wr_en;              // write strobe
	logic [7:0] sfr_wdata;              // write data
	logic [7:0] sfr_rdata;              // registered read data
	logic       timer_irq_enable;       // global timer interrupt enable
	logic       high_byte_clock_select; // high byte on system clock
	logic       low_byte_clock_select;  // low byte on system clock
	logic       ext_osc;                // external oscillator pin
	logic       timer_irq;              // interrupt request
	int         n_fail;                 // mismatches seen
	int         compares;               // comparisons made
	logic [7:0] d;                      // scratch read value
	logic [15:0] c0;                    // first capture
	logic [15:0] c1;                    // second capture

	t2r_timer t2r_timer_i (
		.clk                    (clk),
		.reset_n                (reset_n),
		.sfr_addr               (sfr_addr),
		.sfr_wr_en              (sfr_wr_en),
		.sfr_wdata              (sfr_wdata),
		.sfr_rdata              (sfr_rdata),
		.timer_irq_enable       (timer_irq_enable),
		.high_byte_clock_select (high_byte_clock_select),
		.low_byte_clock_select  (low_byte_clock_select),
		.ext_osc                (ext_osc),
		.timer_irq              (timer_irq)
	);

	// clock generator
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// oscillator pin toggles every four clocks, so one divided event every 64 clocks
	initial
	begin
		ext_osc = 1'b0;
		forever
		begin
			repeat (4) @(posedge clk);
			#10 ext_osc = ~ext_osc;
		end
	end

	// prints the counts and the verdict, then stops
	task automatic final_report();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// one comparison, reported at once on mismatch
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// single-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		#10;
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr_en = 1'b1;
		@(posedge clk);
		#10;
		sfr_wr_en = 1'b0;
	endtask : wr

	// read data is registered, so it is taken one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		#10;
		sfr_addr = a;
		@(posedge clk);
		#10;
		v = sfr_rdata;
	endtask : rd

	// polls a control bit under a bound; a timeout ends the run
	task automatic wait_bit(input int b);
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < 100 && v[b] !== 1'b1; i++)
			rd(T2R_ADDR_CONTROL, v);
		if (v[b] !== 1'b1)
		begin
			n_fail++;
			$display("wrong value at %0t: flag wait timed out", $time);
			final_report();
		end
	endtask : wait_bit

	// counts low byte ticks over n+2 clocks from a stopped, zeroed counter
	task automatic rate(input logic sel, input logic [7:0] ctrl, input int n,
		input logic [7:0] exp);
		logic [7:0] a;
		logic [7:0] b;
		wr(T2R_ADDR_CONTROL, 8'h00);
		low_byte_clock_select = sel;
		wr(T2R_ADDR_COUNT_LOW, 8'h00);
		wr(T2R_ADDR_COUNT_HIGH, 8'h00);
		wr(T2R_ADDR_CONTROL, ctrl);
		rd(T2R_ADDR_COUNT_LOW, a);
		repeat (n) @(posedge clk);
		rd(T2R_ADDR_COUNT_LOW, b);
		chk(b - a, exp);
	endtask : rate

	// main sequence
	initial
	begin
		n_fail = 0;
		compares = 0;
		reset_n = 1'b0;
		sfr_addr = 8'h00;
		sfr_wr_en = 1'b0;
		sfr_wdata = 8'h00;
		timer_irq_enable = 1'b0;
		high_byte_clock_select = 1'b0;
		low_byte_clock_select = 1'b0;
		repeat (8) @(posedge clk);
		#10 reset_n = 1'b1;
		repeat (3) @(posedge clk);
		// unmapped write must leave every register at its reset value
		wr(8'hc9, 8'hff);
		rd(T2R_ADDR_CONTROL, d);
		chk(d, 8'h00);
		rd(T2R_ADDR_RELOAD_LOW, d);
		chk(d, 8'h00);
		rd(T2R_ADDR_RELOAD_HIGH, d);
		chk(d, 8'h00);
		rd(T2R_ADDR_COUNT_LOW, d);
		chk(d, 8'h00);
		rd(T2R_ADDR_COUNT_HIGH, d);
		chk(d, 8'h00);
		rd(8'hc9, d);
		chk(d, 8'h00);
		// all bits written: the unused bit reads zero, flags with enables raise the request
		timer_irq_enable = 1'b1;
		wr(T2R_ADDR_CONTROL, 8'hff);
		rd(T2R_ADDR_CONTROL, d);
		chk(d, 8'hfd);
		chk({7'h00, timer_irq}, 8'h01);
		wr(T2R_ADDR_CONTROL, 8'h00);
		rd(T2R_ADDR_CONTROL, d);
		chk(d, 8'h00);
		chk({7'h00, timer_irq}, 8'h00);
		// 16-bit overflow on the divide-by-12 clock, low enable kept clear
		wr(T2R_ADDR_RELOAD_LOW, 8'h34);
		wr(T2R_ADDR_RELOAD_HIGH, 8'h12);
		wr(T2R_ADDR_COUNT_LOW, 8'hff);
		wr(T2R_ADDR_COUNT_HIGH, 8'hff);
		wr(T2R_ADDR_CONTROL, 8'h04);
		wait_bit(7);
		rd(T2R_ADDR_COUNT_LOW, d);
		chk(d, 8'h34);
		rd(T2R_ADDR_COUNT_HIGH, d);
		chk(d, 8'h12);
		chk({7'h00, timer_irq}, 8'h01);
		repeat (30) @(posedge clk);
		rd(T2R_ADDR_CONTROL, d);
		chk(d, 8'hc4);
		// low byte rollover alone, with its interrupt enabled; the high select
		// is set to show that 16-bit mode ignores it
		wr(T2R_ADDR_CONTROL, 8'h00);
		wr(T2R_ADDR_COUNT_LOW, 8'hff);
		wr(T2R_ADDR_COUNT_HIGH, 8'h00);
		high_byte_clock_select = 1'b1;
		wr(T2R_ADDR_CONTROL, 8'h24);
		wait_bit(6);
		rd(T2R_ADDR_CONTROL, d);
		chk(d, 8'h64);
		rd(T2R_ADDR_COUNT_HIGH, d);
		chk(d, 8'h01);
		chk({7'h00, timer_irq}, 8'h01);
		// split mode: low byte free-running, high byte held while run is clear
		wr(T2R_ADDR_CONTROL, 8'h00);
		high_byte_clock_select = 1'b1;
		low_byte_clock_select = 1'b1;
		wr(T2R_ADDR_RELOAD_LOW, 8'hf0);
		wr(T2R_ADDR_COUNT_LOW, 8'hfe);
		wr(T2R_ADDR_COUNT_HIGH, 8'hfd);
		wr(T2R_ADDR_CONTROL, 8'h08);
		wait_bit(6);
		rd(T2R_ADDR_CONTROL, d);
		chk(d, 8'h48);
		chk({7'h00, timer_irq}, 8'h00);
		rd(T2R_ADDR_COUNT_HIGH, d);
		chk(d, 8'hfd);
		rd(T2R_ADDR_COUNT_LOW, d);
		chk({7'h00, d >= 8'hf0}, 8'h01);
		wr(T2R_ADDR_CONTROL, 8'h68);
		rd(T2R_ADDR_CONTROL, d);
		chk({7'h00, timer_irq}, 8'h01);
		// high byte overflow in split mode with run set
		wr(T2R_ADDR_RELOAD_HIGH, 8'hab);
		wr(T2R_ADDR_COUNT_HIGH, 8'hff);
		wr(T2R_ADDR_CONTROL, 8'h0c);
		wait_bit(7);
		rd(T2R_ADDR_COUNT_HIGH, d);
		chk({7'h00, d >= 8'hab}, 8'h01);
		chk({7'h00, timer_irq}, 8'h01);
		high_byte_clock_select = 1'b0;
		// clock sources: system clock, divide by 12, divided oscillator
		rate(1'b1, 8'h04, 18, 8'h14);
		rate(1'b0, 8'h04, 118, 8'h0a);
		rate(1'b0, 8'h05, 126, 8'h02);
		// capture: successive captures differ by one divided oscillator period;
		// 16-bit mode on the fast system clock, as software is told to do
		wr(T2R_ADDR_CONTROL, 8'h00);
		low_byte_clock_select = 1'b1;
		wr(T2R_ADDR_COUNT_LOW, 8'h00);
		wr(T2R_ADDR_COUNT_HIGH, 8'h00);
		wr(T2R_ADDR_CONTROL, 8'h14);
		wait_bit(7);
		rd(T2R_ADDR_RELOAD_LOW, c0[7:0]);
		rd(T2R_ADDR_RELOAD_HIGH, c0[15:8]);
		wr(T2R_ADDR_CONTROL, 8'h14);
		wait_bit(7);
		rd(T2R_ADDR_RELOAD_LOW, c1[7:0]);
		rd(T2R_ADDR_RELOAD_HIGH, c1[15:8]);
		c1 = c1 - c0;
		chk(c1[7:0], 8'h40);
		chk(c1[15:8], 8'h00);
		// slow the counter first: on the system clock the low byte would roll
		// over during the quiet wait and set its flag
		low_byte_clock_select = 1'b0;
		// capture off: no flag over two divided oscillator periods
		wr(T2R_ADDR_CONTROL, 8'h04);
		repeat (140) @(posedge clk);
		rd(T2R_ADDR_CONTROL, d);
		chk(d, 8'h04);
		final_report();
	end
endmodule : t2r_timer_tb
